// ### verilog/qdc_pkg.sv
// package: constants and types of the quad converter load control
package qdc_pkg;

  // ==========================================================
  // serial word layout
  localparam int         QDC_WORD_W    = 16;
  localparam int         QDC_DATA_W    = 12;
  localparam int         QDC_NCH       = 4;
  localparam int         QDC_CNT_W     = 5;
  localparam int         QDC_EVT_W     = 8;
  localparam logic [4:0] QDC_WORD_BITS = 5'h10;
  localparam logic [4:0] QDC_LAST_BIT  = 5'h0F;
  localparam int         QDC_LD_POS    = 14;
  localparam int         QDC_SEL_POS   = 12;
  localparam int         QDC_ALL_POS   = 11;
  localparam int         QDC_PDCH_POS  = 9;
  localparam int         QDC_TERM_POS  = 7;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] QDC_OFS_CTRL  = 8'h00;
  localparam logic [7:0] QDC_OFS_STAT  = 8'h04;
  localparam logic [7:0] QDC_OFS_PD    = 8'h08;
  localparam logic [3:0] QDC_OFS_CHBLK = 4'h1;
  localparam int         QDC_CTRL_EN   = 0;
  localparam int         QDC_CTRL_CLR  = 1;
  localparam logic       QDC_EN_RST    = 1'b1;
  localparam int         QDC_STAT_ACT  = 8;
  localparam int         QDC_STAT_DONE = 9;
  localparam int         QDC_STAT_WRD  = 16;
  localparam int         QDC_STAT_ABT  = 24;
  localparam int         QDC_PD_TERM   = 4;
  localparam int         QDC_CH_IN     = 16;
  localparam logic [2:0] QDC_HSIZE_W   = 3'h2;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } qdc_state_t;

  typedef enum logic [1:0] {
    LD_STORE  = 2'h0,
    LD_UPDATE = 2'h1,
    LD_BOTH   = 2'h2,
    LD_EXT    = 2'h3
  } qdc_load_t;

  typedef enum logic [1:0] {
    TERM_HIZ  = 2'h0,
    TERM_1K   = 2'h1,
    TERM_100K = 2'h2
  } qdc_term_t;

endpackage : qdc_pkg

// ### verilog/qdc_serial_load.sv
// module: serial word receiver, command decoder and AHB-Lite registers
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
module qdc_serial_load
  import qdc_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // serial link pins
  input  wire logic                  sclk_pin,
  input  wire logic                  sync_b_pin,
  input  wire logic                  sdin_pin,
  // channel codes
  output logic      [QDC_DATA_W-1:0] dac_code_a,
  output logic      [QDC_DATA_W-1:0] dac_code_b,
  output logic      [QDC_DATA_W-1:0] dac_code_c,
  output logic      [QDC_DATA_W-1:0] dac_code_d,
  // power-down state
  output logic      [QDC_NCH-1:0]    pd_active,
  output qdc_term_t                  term_a,
  output qdc_term_t                  term_b,
  output qdc_term_t                  term_c,
  output qdc_term_t                  term_d
);

  // ==========================================================
  // helpers
  function automatic logic [QDC_NCH-1:0] chan_hit(
    input logic [1:0] s
  );
    chan_hit = 4'h1 << s;
  endfunction : chan_hit

  function automatic qdc_term_t term_map(
    input logic [1:0] t
  );
    case (t)
      2'h1:    term_map = TERM_1K;
      2'h2:    term_map = TERM_100K;
      default: term_map = TERM_HIZ;
    endcase
  endfunction : term_map

  // ==========================================================
  // pin synchronisers
  logic [2:0] sclk_s_reg;
  logic [1:0] sync_s_reg;
  logic [1:0] sdin_s_reg;
  logic       sclk_fall;
  logic       sync_hi;
  logic       sdin_s;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // link clock idles high: no false fall after reset
      sclk_s_reg <= 3'h7;
      sync_s_reg <= 2'h3;
      sdin_s_reg <= 2'h0;
    end
    else
    begin
      sclk_s_reg <= {sclk_s_reg[1:0], sclk_pin};
      sync_s_reg <= {sync_s_reg[0], sync_b_pin};
      sdin_s_reg <= {sdin_s_reg[0], sdin_pin};
    end
  end

  assign sclk_fall = sclk_s_reg[2] & ~sclk_s_reg[1];
  assign sync_hi   = sync_s_reg[1];
  assign sdin_s    = sdin_s_reg[1];

  // ==========================================================
  // frame receiver
  qdc_state_t            state_reg;
  qdc_state_t            state_next;
  logic [QDC_CNT_W-1:0]  cnt_reg;
  logic [QDC_CNT_W-1:0]  cnt_next;
  logic [QDC_WORD_W-1:0] shift_reg;
  logic [QDC_WORD_W-1:0] shift_next;
  logic                  cmd_reg;
  logic                  cmd_next;
  logic [QDC_EVT_W-1:0]  words_reg;
  logic [QDC_EVT_W-1:0]  words_next;
  logic [QDC_EVT_W-1:0]  aborts_reg;
  logic [QDC_EVT_W-1:0]  aborts_next;
  logic                  en_reg;

  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    shift_next  = shift_reg;
    cmd_next    = 1'b0;
    words_next  = words_reg;
    aborts_next = aborts_reg;
    case (state_reg)
      ST_IDLE:
      begin
        cnt_next = '0;
        // frame opens on the low level; host gives setup to first fall
        if (!sync_hi && en_reg)
          state_next = ST_SHIFT;
      end
      ST_SHIFT:
      begin
        if (sync_hi)
        begin
          // early release: drop the partial word
          state_next  = ST_IDLE;
          cnt_next    = '0;
          aborts_next = aborts_reg + 8'h01;
        end
        else if (sclk_fall)
        begin
          shift_next = {shift_reg[QDC_WORD_W-2:0], sdin_s};
          cnt_next   = cnt_reg + 5'h01;
          if (cnt_reg == QDC_LAST_BIT)
          begin
            state_next = ST_DONE;
            cmd_next   = 1'b1;
            words_next = words_reg + 8'h01;
          end
        end
      end
      ST_DONE:
      begin
        // further clocks ignored until frame select is high again
        if (sync_hi)
        begin
          state_next = ST_IDLE;
          cnt_next   = '0;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= '0;
      shift_reg  <= '0;
      cmd_reg    <= 1'b0;
      words_reg  <= '0;
      aborts_reg <= '0;
    end
    else
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      shift_reg  <= shift_next;
      cmd_reg    <= cmd_next;
      words_reg  <= words_next;
      aborts_reg <= aborts_next;
    end
  end

  // ==========================================================
  // command decoder and channel registers
  logic [QDC_DATA_W-1:0] in_reg   [QDC_NCH];
  logic [QDC_DATA_W-1:0] in_next  [QDC_NCH];
  logic [QDC_DATA_W-1:0] dac_reg  [QDC_NCH];
  logic [QDC_DATA_W-1:0] dac_next [QDC_NCH];
  logic [QDC_NCH-1:0]    pd_reg;
  logic [QDC_NCH-1:0]    pd_next;
  qdc_term_t             term_reg  [QDC_NCH];
  qdc_term_t             term_next [QDC_NCH];
  qdc_load_t             ld;
  qdc_load_t             mode;
  logic [1:0]            sel;
  logic [QDC_DATA_W-1:0] data;
  logic [QDC_NCH-1:0]    hit;
  logic [QDC_NCH-1:0]    pd_hit;
  logic                  pd_cmd;
  logic                  clr_reg;

  always_comb
  begin
    ld     = qdc_load_t'(shift_reg[QDC_LD_POS +: 2]);
    sel    = shift_reg[QDC_SEL_POS +: 2];
    data   = shift_reg[QDC_DATA_W-1:0];
    pd_cmd = (ld == LD_EXT) && (sel == 2'h3);
    // all-channel forms take their function from the pick field
    mode   = (ld == LD_EXT) ? qdc_load_t'(sel) : ld;
    hit    = (ld == LD_EXT) ? 4'hF : chan_hit(sel);
    pd_hit = shift_reg[QDC_ALL_POS] ? 4'hF :
             chan_hit(shift_reg[QDC_PDCH_POS +: 2]);
    pd_next = pd_reg;
    for (int i = 0; i < QDC_NCH; i++)
    begin
      in_next[i]   = in_reg[i];
      dac_next[i]  = dac_reg[i];
      term_next[i] = term_reg[i];
      if (clr_reg)
      begin
        in_next[i]   = '0;
        dac_next[i]  = '0;
        pd_next[i]   = 1'b0;
        term_next[i] = TERM_HIZ;
      end
      else if (cmd_reg && pd_cmd)
      begin
        if (pd_hit[i])
        begin
          pd_next[i]   = 1'b1;
          term_next[i] = term_map(shift_reg[QDC_TERM_POS +: 2]);
        end
      end
      else if (cmd_reg && hit[i])
      begin
        if (mode != LD_UPDATE)
          in_next[i] = data;
        if (mode == LD_UPDATE)
          dac_next[i] = in_reg[i];
        else if (mode == LD_BOTH)
          dac_next[i] = data;
        // a fresh output code brings the channel back up
        if (mode != LD_STORE)
          pd_next[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pd_reg <= '0;
      for (int i = 0; i < QDC_NCH; i++)
      begin
        in_reg[i]   <= '0;
        dac_reg[i]  <= '0;
        term_reg[i] <= TERM_HIZ;
      end
    end
    else
    begin
      pd_reg <= pd_next;
      for (int i = 0; i < QDC_NCH; i++)
      begin
        in_reg[i]   <= in_next[i];
        dac_reg[i]  <= dac_next[i];
        term_reg[i] <= term_next[i];
      end
    end
  end

  // unsigned straight binary codes
  assign dac_code_a = dac_reg[0];
  assign dac_code_b = dac_reg[1];
  assign dac_code_c = dac_reg[2];
  assign dac_code_d = dac_reg[3];
  assign pd_active  = pd_reg;
  assign term_a     = term_reg[0];
  assign term_b     = term_reg[1];
  assign term_c     = term_reg[2];
  assign term_d     = term_reg[3];

  // ==========================================================
  // ahb-lite slave, zero wait states
  logic        addr_ok;
  logic        wr_reg;
  logic        wr_next;
  logic [7:0]  wa_reg;
  logic [7:0]  wa_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic [31:0] rd_val;
  logic        en_next;
  logic        clr_next;
  logic        rdy_reg;
  logic        resp_reg;

  always_comb
  begin
    rd_val = 32'h0;
    if (haddr[7:0] == QDC_OFS_CTRL)
      rd_val[QDC_CTRL_EN] = en_reg;
    else if (haddr[7:0] == QDC_OFS_STAT)
    begin
      rd_val[QDC_CNT_W-1:0]             = cnt_reg;
      rd_val[QDC_STAT_ACT]              = state_reg == ST_SHIFT;
      rd_val[QDC_STAT_DONE]             = state_reg == ST_DONE;
      rd_val[QDC_STAT_WRD +: QDC_EVT_W] = words_reg;
      rd_val[QDC_STAT_ABT +: QDC_EVT_W] = aborts_reg;
    end
    else if (haddr[7:0] == QDC_OFS_PD)
    begin
      rd_val[QDC_NCH-1:0] = pd_reg;
      for (int i = 0; i < QDC_NCH; i++)
        rd_val[QDC_PD_TERM + 2*i +: 2] = term_reg[i];
    end
    else if (haddr[7:4] == QDC_OFS_CHBLK)
    begin
      rd_val[QDC_DATA_W-1:0]           = dac_reg[haddr[3:2]];
      rd_val[QDC_CH_IN +: QDC_DATA_W]  = in_reg[haddr[3:2]];
    end
  end

  always_comb
  begin
    addr_ok  = hsel && htrans[1] && hready;
    wr_next  = addr_ok && hwrite && (hsize == QDC_HSIZE_W);
    wa_next  = addr_ok ? haddr[7:0] : wa_reg;
    rd_next  = (addr_ok && !hwrite) ? rd_val : rd_reg;
    en_next  = en_reg;
    clr_next = 1'b0;
    if (wr_reg && wa_reg == QDC_OFS_CTRL)
    begin
      en_next  = hwdata[QDC_CTRL_EN];
      clr_next = hwdata[QDC_CTRL_CLR];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_reg   <= 1'b0;
      wa_reg   <= 8'h00;
      rd_reg   <= 32'h0;
      en_reg   <= QDC_EN_RST;
      clr_reg  <= 1'b0;
      rdy_reg  <= 1'b1;
      resp_reg <= 1'b0;
    end
    else
    begin
      wr_reg   <= wr_next;
      wa_reg   <= wa_next;
      rd_reg   <= rd_next;
      en_reg   <= en_next;
      clr_reg  <= clr_next;
      rdy_reg  <= 1'b1;
      resp_reg <= 1'b0;
    end
  end

  assign hrdata    = rd_reg;
  assign hreadyout = rdy_reg;
  assign hresp     = resp_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_last_fall;
    state_reg == ST_SHIFT && !sync_hi && sclk_fall && cnt_reg == QDC_LAST_BIT;
  endsequence

  sequence s_early_rise;
    state_reg == ST_SHIFT && sync_hi;
  endsequence

  sequence s_single_store0;
    cmd_reg && !clr_reg && shift_reg[15:12] == 4'h0;
  endsequence

  AST_CNT_BOUND: assert property (
    cnt_reg <= QDC_WORD_BITS)
    else $error("bit count above sixteen");

  AST_WORD_CMD: assert property (
    s_last_fall |=> cmd_reg && state_reg == ST_DONE ##1 !cmd_reg)
    else $error("complete word not issued once");

  AST_CNT_CLEAR: assert property (
    sync_hi |=> cnt_reg == '0)
    else $error("bit count kept while frame select high");

  AST_NO_SHIFT_HIGH: assert property (
    sync_hi |=> $stable(shift_reg))
    else $error("shift while frame select high");

  AST_IGNORE_EXTRA: assert property (
    state_reg == ST_DONE && !sync_hi |=> $stable(shift_reg) && !cmd_reg)
    else $error("extra bits taken after sixteenth fall");

  AST_ABORT: assert property (
    s_early_rise |=> !cmd_reg ##1 (!cmd_reg && $stable(in_reg[0])))
    else $error("aborted frame changed a channel");

  AST_STORE_A: assert property (
    s_single_store0 |=> in_reg[0] == shift_reg[11:0] && $stable(dac_reg[0]))
    else $error("store to channel A wrong");

  AST_ALL_UPDATE: assert property (
    cmd_reg && !clr_reg && shift_reg[15:12] == 4'hD
    |=> dac_reg[1] == $past(in_reg[1]) && dac_reg[3] == $past(in_reg[3]))
    else $error("all-channel update wrong");

  AST_PD_ALL: assert property (
    cmd_reg && !clr_reg && shift_reg[15:11] == 5'h1F |=> pd_reg == 4'hF)
    else $error("all-channel power-down missed");

  AST_PD_TERM: assert property (
    cmd_reg && !clr_reg && shift_reg[15:7] == 9'h1E3
    |=> pd_reg[0] && term_reg[0] == TERM_HIZ)
    else $error("termination code 11 not high impedance");

endmodule : qdc_serial_load

// ### tb/qdc_host_model.sv
// host serial master that drives frames into the converter link
`timescale 1ns/1ns
module qdc_host_model
(
  // clock
  input  logic clk,
  // serial link pins
  output logic sclk,
  output logic sync_b,
  output logic sdin
);
  // ==========================================================
  // idle link: clock parked high, frame select high
  initial
  begin
    sclk   = 1'b1;
    sync_b = 1'b1;
    sdin   = 1'b0;
  end

  // ==========================================================
  // one frame of n falling clock edges, 80 ns link period
  task automatic send(input logic [15:0] w, input int n);
    @(posedge clk);
    sync_b <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdin <= (i < 16) ? w[15-i] : ~sdin;
      repeat (5) @(posedge clk);
      sclk <= 1'b0;
      repeat (5) @(posedge clk);
      sclk <= 1'b1;
    end
    sync_b <= 1'b1;
    sdin   <= ~sdin;
    repeat (10) @(posedge clk);
  endtask : send
endmodule : qdc_host_model

// ### tb/tb_top.sv
// testbench: serial load control against a behavioural model
`timescale 1ns/1ns
module tb_top
  import qdc_pkg::*;
;
  // ==========================================================
  // signals
  logic        clk    = 1'b0;
  logic        rst_b  = 1'b0;
  logic        hsel   = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize  = 3'h0;
  logic [2:0]  sz     = QDC_HSIZE_W;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sclk;
  logic        sync_b;
  logic        sdin;
  logic [11:0] code [4];
  logic [3:0]  pd_active;
  qdc_term_t   term [4];
  int          fails   = 0;
  int          checked = 0;
  int          cyc     = 0;
  int          words   = 0;
  int          aborts  = 0;
  int          inreg [4] = '{default: 0};
  int          dacreg [4] = '{default: 0};
  int          pd [4] = '{default: 0};
  int          tm [4] = '{default: 0};
  logic [31:0] r;

  qdc_serial_load dut (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sclk_pin(sclk), .sync_b_pin(sync_b), .sdin_pin(sdin),
    .dac_code_a(code[0]), .dac_code_b(code[1]), .dac_code_c(code[2]),
    .dac_code_d(code[3]), .pd_active(pd_active), .term_a(term[0]),
    .term_b(term[1]), .term_c(term[2]), .term_d(term[3])
  );

  qdc_host_model host (
    .clk(clk),
    .sclk(sclk),
    .sync_b(sync_b),
    .sdin(sdin)
  );

  always #4 clk = ~clk;

  // ==========================================================
  // verdict and hang limit
  task finish_test;
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      finish_test();
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // ==========================================================
  // ahb-lite single word transfer
  task xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    hsize  <= sz;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : xfer

  // ==========================================================
  // behavioural model of the command decoder
  task automatic apply(input logic [15:0] w);
    int ld;
    int sel;
    int m;
    int t;
    ld  = w[15:14];
    sel = w[13:12];
    t   = (w[8:7] == 2'h3) ? 0 : w[8:7];
    words++;
    for (int c = 0; c < 4; c++)
    begin
      m = (ld == 3) ? sel : ld;
      if (ld == 3 && sel == 3)
      begin
        if (w[11] || c == w[10:9])
        begin
          pd[c] = 1;
          tm[c] = t;
        end
      end
      else if (ld == 3 || c == sel)
      begin
        if (m != 1) inreg[c] = w[11:0];
        if (m != 0)
        begin
          dacreg[c] = inreg[c];
          pd[c]     = 0;
        end
      end
    end
  endtask : apply

  task check_all;
    logic [3:0]  pv;
    logic [31:0] pe;
    pv = '0;
    pe = '0;
    for (int c = 0; c < 4; c++)
    begin
      xfer(32'h10 + 4 * c, 1'b0, 32'h0);
      chk(r, {4'h0, 12'(inreg[c]), 4'h0, 12'(dacreg[c])});
      chk(code[c], dacreg[c]);
      chk(term[c], tm[c]);
      pv[c] = pd[c][0];
      pe[QDC_PD_TERM + 2 * c +: 2] = 2'(tm[c]);
    end
    pe[3:0] = pv;
    chk(pd_active, pv);
    xfer(QDC_OFS_PD, 1'b0, 32'h0);
    chk(r, pe);
    xfer(QDC_OFS_STAT, 1'b0, 32'h0);
    chk(r, {aborts[7:0], words[7:0], 16'h0});
  endtask : check_all

  task frame(input logic [15:0] w, input int n);
    host.send(w, n);
    repeat (8) @(posedge clk);
    if (n >= 16) apply(w);
    else aborts++;
    check_all();
  endtask : frame

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(86));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    check_all();
    xfer(32'h40, 1'b0, 32'h0);
    chk(r, 32'h0);
    // a byte-sized write must not touch the link enable
    sz = 3'h0;
    xfer(QDC_OFS_CTRL, 1'b1, 32'h0);
    sz = QDC_HSIZE_W;
    xfer(QDC_OFS_CTRL, 1'b0, 32'h0);
    chk(r, 32'h1);
    for (int m = 0; m < 3; m++)
      for (int c = 0; c < 4; c++)
        frame({m[1:0], c[1:0], 12'($urandom)}, 16);
    for (int s = 0; s < 3; s++)
      frame({2'h3, s[1:0], 12'($urandom)}, 16);
    for (int t = 0; t < 4; t++)
      for (int c = 0; c < 4; c++)
        frame({4'hF, 1'b0, c[1:0], t[1:0], 7'($urandom)}, 16);
    frame({4'hF, 1'b1, 2'($urandom), 2'h2, 7'($urandom)}, 16);
    frame({4'h8, 12'hFFF}, 16);
    frame(16'($urandom), 9);
    frame({4'h9, 12'h000}, 20);
    for (int k = 0; k < 20; k++)
      frame(16'($urandom), 16);
    // link disabled: frame must leave everything alone
    xfer(QDC_OFS_CTRL, 1'b1, 32'h0);
    host.send(16'h8ABC, 16);
    repeat (8) @(posedge clk);
    check_all();
    xfer(QDC_OFS_CTRL, 1'b1, 32'h3);
    repeat (4) @(posedge clk);
    for (int c = 0; c < 4; c++)
    begin
      inreg[c]  = 0;
      dacreg[c] = 0;
      pd[c]     = 0;
      tm[c]     = 0;
    end
    check_all();
    xfer(QDC_OFS_CTRL, 1'b0, 32'h0);
    chk(r, 32'h1);
    frame({4'hA, 12'h5A5}, 16);
    finish_test();
  end
endmodule : tb_top
